// ---- smb_map.svh ----
// register offsets, fixed addresses and timing figures of the smbus slave
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
`define ADDR_FIXED_HI  3'h2
`define ADDR_BCAST     7'h30
`define ADDR_ARA       7'h0C
`define REG_FLAGS      5'h00
`define REG_INT_CMD    5'h1A
`define BIT_CLR_ALL    7
`define BIT_REL_INT    6
`define FLAGS_RST      8'h00
`define MCLK_PERIOD_NS 100
`define STOP_HOLD_NS   300
`endif

// ---- smb_pkg.sv ----
// types shared by the smbus slave
package smb_pkg;
   typedef enum logic [3:0] {
      LS_IDLE,
      LS_ADDR,
      LS_ACK_A,
      LS_CMD,
      LS_ACK_C,
      LS_DATA,
      LS_ACK_D,
      LS_TX,
      LS_TX_ACK
   } link_state_t;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] data;
   } wr_req_t;
endpackage

// ---- smb_slave.sv ----
// smbus slave front end with alert response and interrupt line control
`include "smb_map.svh"
module smb_slave
   import smb_pkg::*;
#(
   parameter int STOP_HOLD_NS = `STOP_HOLD_NS
) (
   input  wire logic       MCLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic       SCL_IN,
   input  wire logic       SERIAL_DATA_INPUT_PIN_IN,
   output logic            SERIAL_DATA_OUTPUT_PIN_OUT,
   output logic            SERIAL_DATA_OUTPUT_PIN_OE_OUT,
   input  wire logic [3:0] ADDRESS_SELECT_PINS_IN,
   input  wire logic [7:0] EVENT_IN,
   output logic            INT_REQ_OUT,
   output logic            INT_REQ_OE_OUT,
   output logic            BUS_BUSY_OUT,
   output logic            WR_STB_OUT,
   output wr_req_t         WR_REQ_OUT
);
   // bus free time after a stop, rounded up to whole cycles
   localparam int         STOP_CYC_I = (STOP_HOLD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
   localparam logic [7:0] STOP_CYC   = 8'(STOP_CYC_I < 1 ? 1 : STOP_CYC_I);
   // ---------------- system clock domain ----------------
   logic        link_rst_n_r;
   logic        od_lo_r;
   logic [8:0]  sync1_r;
   logic [8:0]  sync2_r;
   logic [2:0]  tgl_q_r;
   logic        armed_r;
   logic [7:0]  hold_r;
   logic        busy_r;
   logic        stop_tgl_r;
   logic [7:0]  flags_r;
   logic [7:0]  ev_pend_r;
   logic        clr_pend_r;
   logic        rel_pend_r;
   logic        released_r;
   logic        int_oe_r;
   logic        wr_stb_r;
   wr_req_t     wr_out_r;
   // ---------------- link clock domain ----------------
   link_state_t state_r;
   logic [3:0]  cnt_r;
   logic [7:0]  sh_r;
   logic        oe_r;
   logic        rw_r;
   logic        ara_r;
   logic [4:0]  ptr_r;
   logic        sda_p_r;
   logic        stop_ack_r;
   logic        start_tgl_r;
   logic        ara_tgl_r;
   logic        wr_tgl_r;
   wr_req_t     wr_req_r;
   // both line levels, straps and the three link event toggles share one synchroniser
   wire logic [8:0] async_in = {SCL_IN, SERIAL_DATA_INPUT_PIN_IN, ADDRESS_SELECT_PINS_IN,
                                start_tgl_r, ara_tgl_r, wr_tgl_r};
   wire logic       scl_s     = sync2_r[8];
   wire logic       sda_s     = sync2_r[7];
   wire logic [6:0] own_addr  = {`ADDR_FIXED_HI, sync2_r[6:3]};
   wire logic [2:0] tev       = sync2_r[2:0] ^ tgl_q_r;
   wire logic       start_evt = tev[2];
   wire logic       ara_evt   = tev[1];
   wire logic       wr_evt    = tev[0];
   // stop: data rises under a high clock, then a quiet spell so aliasing cannot fake it
   wire logic       quiet     = armed_r & scl_s & sda_s;
   wire logic       stop_fire = quiet & (hold_r == STOP_CYC - 8'h01);
   wire logic       armed_nxt = (scl_s & ~sda_s) | (armed_r & scl_s & ~stop_fire);
   wire logic [7:0] hold_nxt  = quiet ? hold_r + 8'h01 : 8'h00;
   // a start before any stop keeps the bus busy, so no interrupt until stop
   wire logic       busy_nxt  = (start_evt | (scl_s & ~sda_s)) | (busy_r & ~stop_fire);
   wire logic       idle      = ~busy_r;
   // commands written during a transaction wait for the bus to go idle
   wire logic       cmd_hit  = wr_evt & (wr_req_r.addr == `REG_INT_CMD);
   wire logic       clr_now  = cmd_hit & wr_req_r.data[`BIT_CLR_ALL];
   wire logic       rel_now  = (cmd_hit & wr_req_r.data[`BIT_REL_INT]) | ara_evt;
   wire logic       clr_go   = idle & (clr_pend_r | clr_now);
   wire logic       rel_go   = idle & (rel_pend_r | rel_now);
   wire logic [7:0] ev_go    = idle ? (ev_pend_r | EVENT_IN) : 8'h00;
   // new events win over a clear arriving in the same cycle
   wire logic [7:0] flags_nxt = (clr_go ? `FLAGS_RST : flags_r) | ev_go;
   wire logic       rel_nxt   = rel_go | (released_r & ~clr_go & (|flags_r));
   wire logic       int_nxt   = idle ? ((|flags_nxt) & ~rel_nxt) : int_oe_r;
   wire logic       fwd_wr    = wr_evt & (wr_req_r.addr != `REG_INT_CMD)
                                & (wr_req_r.addr != `REG_FLAGS);
   // synchronisers and the reset handed to the link domain
   always_ff @(posedge MCLK_IN) begin
      link_rst_n_r <= RST_N_IN;
      if (!RST_N_IN) begin
         sync1_r <= 9'h000;
         sync2_r <= 9'h000;
         tgl_q_r <= 3'h0;
      end else begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
         tgl_q_r <= sync2_r[2:0];
      end
   end
   // bus watch: start and stop tracking
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         armed_r    <= 1'b0;
         hold_r     <= 8'h00;
         busy_r     <= 1'b0;
         stop_tgl_r <= 1'b0;
      end else begin
         armed_r    <= armed_nxt;
         hold_r     <= hold_nxt;
         busy_r     <= busy_nxt;
         stop_tgl_r <= stop_tgl_r ^ stop_fire;
      end
   end
   // interrupt flags, release state and the line itself
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         flags_r    <= `FLAGS_RST;
         ev_pend_r  <= 8'h00;
         clr_pend_r <= 1'b0;
         rel_pend_r <= 1'b0;
         released_r <= 1'b0;
         int_oe_r   <= 1'b0;
      end else begin
         flags_r    <= flags_nxt;
         ev_pend_r  <= idle ? 8'h00 : (ev_pend_r | EVENT_IN);
         clr_pend_r <= ~idle & (clr_pend_r | clr_now);
         rel_pend_r <= ~idle & (rel_pend_r | rel_now);
         released_r <= rel_nxt;
         int_oe_r   <= int_nxt;
      end
   end
   // writes to registers kept outside this block
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         wr_stb_r <= 1'b0;
         wr_out_r <= '0;
         od_lo_r  <= 1'b0;
      end else begin
         wr_stb_r <= fwd_wr;
         wr_out_r <= fwd_wr ? wr_req_r : wr_out_r;
         od_lo_r  <= 1'b0;
      end
   end
   assign INT_REQ_OUT                   = od_lo_r;
   assign INT_REQ_OE_OUT                = int_oe_r;
   assign BUS_BUSY_OUT                  = busy_r;
   assign WR_STB_OUT                    = wr_stb_r;
   assign WR_REQ_OUT                    = wr_out_r;
   assign SERIAL_DATA_OUTPUT_PIN_OUT    = od_lo_r;
   assign SERIAL_DATA_OUTPUT_PIN_OE_OUT = oe_r;
   // ---------------- link side, clocked by the bus clock ----------------
   // flags, straps, interrupt and stop toggle change only on an idle bus: safe as levels
   wire logic       stop_pend = stop_tgl_r ^ stop_ack_r;
   wire logic       start_now = ~SERIAL_DATA_INPUT_PIN_IN & (sda_p_r | stop_pend);
   wire logic [7:0] rx_byte   = {sh_r[6:0], sda_p_r};
   wire logic       last      = cnt_r == 4'h7;
   wire logic       hit_prim  = rx_byte[7:1] == own_addr;
   wire logic       hit_bc    = (rx_byte[7:1] == `ADDR_BCAST) & ~rx_byte[0];
   wire logic       hit_ara   = (rx_byte[7:1] == `ADDR_ARA) & rx_byte[0] & int_oe_r;
   wire logic [7:0] rd_byte   = (ptr_r == `REG_FLAGS) ? flags_r : 8'h00;
   wire logic [7:0] tx_byte   = ara_r ? {own_addr, 1'b1} : rd_byte;
   wire logic       arb_lost  = ara_r & ~oe_r & ~sda_p_r;
   link_state_t state_nxt;
   logic [3:0]  cnt_nxt;
   logic [7:0]  sh_nxt;
   logic        oe_nxt;
   logic        rw_nxt;
   logic        ara_nxt;
   logic [4:0]  ptr_nxt;
   logic        start_t_nxt;
   logic        ara_t_nxt;
   logic        wr_t_nxt;
   wr_req_t     wr_nxt;
   // protocol sequencer, evaluated at each falling clock edge
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r + 4'h1;
      sh_nxt      = rx_byte;
      oe_nxt      = 1'b0;
      rw_nxt      = rw_r;
      ara_nxt     = ara_r;
      ptr_nxt     = stop_pend ? 5'h00 : ptr_r;
      start_t_nxt = start_tgl_r;
      ara_t_nxt   = ara_tgl_r;
      wr_t_nxt    = wr_tgl_r;
      wr_nxt      = wr_req_r;
      if (start_now) begin
         state_nxt   = LS_ADDR;
         cnt_nxt     = 4'h0;
         start_t_nxt = ~start_tgl_r;
      end else begin
         case (state_r)
            LS_ADDR: begin
               if (last && (hit_prim || hit_bc || hit_ara)) begin
                  oe_nxt    = 1'b1;
                  state_nxt = LS_ACK_A;
                  rw_nxt    = rx_byte[0];
                  ara_nxt   = hit_ara;
               end else if (last) begin
                  state_nxt = LS_IDLE;
               end
            end
            LS_ACK_A: begin
               if (rw_r) begin
                  state_nxt = LS_TX;
                  oe_nxt    = ~tx_byte[7];
                  sh_nxt    = {tx_byte[6:0], 1'b1};
                  cnt_nxt   = 4'h1;
               end else begin
                  state_nxt = LS_CMD;
                  cnt_nxt   = 4'h0;
               end
            end
            LS_CMD: begin
               if (last) begin
                  oe_nxt    = 1'b1;
                  state_nxt = LS_ACK_C;
                  ptr_nxt   = rx_byte[4:0];
               end
            end
            LS_ACK_C: begin
               state_nxt = LS_DATA;
               cnt_nxt   = 4'h0;
            end
            LS_DATA: begin
               if (last) begin
                  oe_nxt    = 1'b1;
                  state_nxt = LS_ACK_D;
                  wr_nxt    = '{addr: ptr_r, data: rx_byte};
                  wr_t_nxt  = ~wr_tgl_r;
               end
            end
            // further write bytes are not part of any supported format
            LS_ACK_D: state_nxt = LS_IDLE;
            LS_TX: begin
               if (arb_lost) begin
                  state_nxt = LS_IDLE;
               end else if (cnt_r == 4'h8) begin
                  state_nxt = LS_TX_ACK;
                  ara_nxt   = 1'b0;
                  ara_t_nxt = ara_tgl_r ^ ara_r;
               end else begin
                  oe_nxt = ~sh_r[7];
                  sh_nxt = {sh_r[6:0], 1'b1};
               end
            end
            LS_TX_ACK: begin
               if (!sda_p_r) begin
                  state_nxt = LS_TX;
                  oe_nxt    = ~tx_byte[7];
                  sh_nxt    = {tx_byte[6:0], 1'b1};
                  cnt_nxt   = 4'h1;
               end else begin
                  state_nxt = LS_IDLE;
               end
            end
            default: state_nxt = LS_IDLE;
         endcase
      end
   end
   // data is sampled on the rising edge; idle bus reads high after reset
   always_ff @(posedge SCL_IN or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         sda_p_r <= 1'b1;
      end else begin
         sda_p_r <= SERIAL_DATA_INPUT_PIN_IN;
      end
   end
   // link registers; the link clock may stand still, hence the async reset
   always_ff @(negedge SCL_IN or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         state_r     <= LS_IDLE;
         cnt_r       <= 4'h0;
         sh_r        <= 8'h00;
         oe_r        <= 1'b0;
         rw_r        <= 1'b0;
         ara_r       <= 1'b0;
         ptr_r       <= 5'h00;
         stop_ack_r  <= 1'b0;
         start_tgl_r <= 1'b0;
         ara_tgl_r   <= 1'b0;
         wr_tgl_r    <= 1'b0;
         wr_req_r    <= '0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         sh_r        <= sh_nxt;
         oe_r        <= oe_nxt;
         rw_r        <= rw_nxt;
         ara_r       <= ara_nxt;
         ptr_r       <= ptr_nxt;
         stop_ack_r  <= stop_tgl_r;
         start_tgl_r <= start_t_nxt;
         ara_tgl_r   <= ara_t_nxt;
         wr_tgl_r    <= wr_t_nxt;
         wr_req_r    <= wr_nxt;
      end
   end
   // ---------------- checks ----------------
   sequence addr_last_s;
      !start_now && state_r == LS_ADDR && cnt_r == 4'h7;
   endsequence
   sequence tx_lost_s;
      !start_now && state_r == LS_TX && ara_r && !oe_r && !sda_p_r;
   endsequence
   prim_ack_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      addr_last_s ##0 hit_prim |=> oe_r && state_r == LS_ACK_A)
      else $error("primary address not acknowledged");
   bcast_ack_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      addr_last_s ##0 (rx_byte == {`ADDR_BCAST, 1'b0}) |=> oe_r ##1 !oe_r)
      else $error("broadcast write not acknowledged");
   ara_gate_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      (state_r == LS_ACK_A && ara_r) |-> int_oe_r && rw_r)
      else $error("alert response taken without interrupt");
   ack_hold_a: assert property (@(posedge SCL_IN) disable iff (!link_rst_n_r)
      state_r inside {LS_ACK_A, LS_ACK_C, LS_ACK_D} |-> oe_r)
      else $error("acknowledge not held low");
   ptr_low_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      (!start_now && state_r == LS_CMD && cnt_r == 4'h7) |=> ptr_r == sh_r[4:0])
      else $error("pointer not taken from command low bits");
   stop_ptr_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      (stop_pend && state_r != LS_CMD) |=> ptr_r == 5'h00)
      else $error("pointer not cleared by stop");
   arb_lost_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      tx_lost_s |=> state_r == LS_IDLE && !oe_r ##1 !oe_r)
      else $error("arbitration loss not aborted");
   nack_rel_a: assert property (@(negedge SCL_IN) disable iff (!link_rst_n_r)
      (!start_now && state_r == LS_TX_ACK && sda_p_r) |=> !oe_r && state_r == LS_IDLE)
      else $error("data line kept after master nack");
   int_idle_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
      $changed(int_oe_r) |-> !$past(busy_r))
      else $error("interrupt line moved during a transaction");
   ara_rel_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
      ara_evt |=> rel_pend_r || released_r)
      else $error("alert response did not release interrupt");
   rel_hold_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
      released_r |-> !int_oe_r)
      else $error("interrupt driven while released");
   clr_all_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
      (clr_go && EVENT_IN == 8'h00 && ev_pend_r == 8'h00) |=> flags_r == 8'h00)
      else $error("clear all left flags set");
endmodule

// ---- smb_host_model.sv ----
// behavioural smbus host: drives the bus clock and pulls the data wire low
module smb_host_model (
   output logic      scl,
   output logic      m_oe,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 10ps;
   // clock and data left high between frames; the clock only runs inside them
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   // data falls while clock high; also used as a repeated start
   task automatic start();
      m_oe = 1'b0;
      #31.25 scl = 1'b1;
      #31.25 m_oe = 1'b1;
      #31.25 scl = 1'b0;
      #31.25;
   endtask
   // data rises while clock high; data stays low long enough under the high
   // clock for the 100 ns system clock watch to see it before the rise
   task automatic stop();
      #31.25 m_oe = 1'b1;
      #31.25 scl = 1'b1;
      #250 m_oe = 1'b0;
      #62.5;
   endtask
   // one bit: data set while the clock is low, sampled mid high phase
   task automatic bit_xfer(input logic b, output logic q);
      #31.25 m_oe = ~b;
      #31.25 scl = 1'b1;
      #31.25 q = sda;
      #31.25 scl = 1'b0;
   endtask
   // msb first; last is the ninth bit, 1 releases data (no acknowledge on reads)
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], q[i]);
      end
      bit_xfer(last, k);
   endtask
endmodule

// ---- smb_slave_tb.sv ----
// self-checking bench for the smbus slave with a behavioural host
`include "smb_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
   $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module smb_slave_tb
   import smb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] PA = 7'h25; // primary address with straps 0101
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] ev_in = 8'h00;
   logic [3:0] straps = 4'h5;
   logic       scl, m_oe, sda_oe, int_oe, busy, wr_stb, k;
   logic       sda_out, int_out;
   logic [7:0] v, r;
   wr_req_t    wr_req, last_wr;
   int         mismatches = 0;
   int         n_compared = 0;
   int         n_stb = 0;
   // data wire with pull-up; an enabled device output shows its open-drain value
   wire        sda   = ~m_oe & (sda_oe ? sda_out : 1'b1);
   wire        int_w = int_oe ? int_out : 1'b1;

   always #50 mclk = ~mclk;

   smb_slave dut_u (
      .MCLK_IN                      (mclk),
      .RST_N_IN                     (rst_n),
      .SCL_IN                       (scl),
      .SERIAL_DATA_INPUT_PIN_IN     (sda),
      .SERIAL_DATA_OUTPUT_PIN_OUT   (sda_out),
      .SERIAL_DATA_OUTPUT_PIN_OE_OUT(sda_oe),
      .ADDRESS_SELECT_PINS_IN       (straps),
      .EVENT_IN                     (ev_in),
      .INT_REQ_OUT                  (int_out),
      .INT_REQ_OE_OUT               (int_oe),
      .BUS_BUSY_OUT                 (busy),
      .WR_STB_OUT                   (wr_stb),
      .WR_REQ_OUT                   (wr_req)
   );
   smb_host_model m_u (.scl(scl), .m_oe(m_oe), .sda(sda));

   // keep the last register write handed out, and count them
   always @(posedge mclk) begin
      if (wr_stb === 1'b1) begin
         n_stb++;
         last_wr = wr_req;
      end
   end

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge mclk) ev_in <= e;
      @(posedge mclk) ev_in <= 8'h00;
      idle(4);
   endtask
   // write byte; ea is the acknowledge level expected after each byte
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input logic ea);
      m_u.start();
      m_u.xfer({a, 1'b0}, 1'b1, r, k);
      `CHK(k, ea)
      m_u.xfer(c, 1'b1, r, k);
      `CHK(k, ea)
      m_u.xfer(d, 1'b1, r, k);
      `CHK(k, ea)
      m_u.stop();
      idle(10);
   endtask
   // receive byte, or read byte when cp is set; rv is what the host puts on data
   task automatic rd(input logic [6:0] a, input logic cp, input logic [7:0] c, rv,
                     input logic ea, output logic [7:0] q);
      m_u.start();
      if (cp) begin
         m_u.xfer({a, 1'b0}, 1'b1, r, k);
         `CHK(k, 1'b0)
         m_u.xfer(c, 1'b1, r, k);
         `CHK(k, 1'b0)
         m_u.start();
      end
      m_u.xfer({a, 1'b1}, 1'b1, r, k);
      `CHK(k, ea)
      m_u.xfer(rv, 1'b1, q, k);
      m_u.stop();
      idle(10);
   endtask

   // reset state, then writes through primary and broadcast addresses
   task automatic t_write();
      `CHK(int_oe, 1'b0)
      rd(PA, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, `FLAGS_RST)
      wr(PA, 8'hE5, 8'hA5, 1'b0);
      `CHK(last_wr, {5'h05, 8'hA5})
      wr(`ADDR_BCAST, 8'h03, 8'h3C, 1'b0);
      `CHK(last_wr, {5'h03, 8'h3C})
      `CHK(n_stb, 2)
   endtask
   // foreign address, broadcast read and alert response with no interrupt
   task automatic t_refuse();
      wr(7'h26, 8'h04, 8'h11, 1'b1);
      rd(`ADDR_BCAST, 1'b0, 8'h00, 8'hFF, 1'b1, v);
      `CHK(v, 8'hFF)
      rd(`ADDR_ARA, 1'b0, 8'h00, 8'hFF, 1'b1, v);
      `CHK(v, 8'hFF)
      `CHK(n_stb, 2)
   endtask
   // register reads with and without a command byte
   task automatic t_read();
      pulse(8'h04);
      `CHK(int_oe, 1'b1)
      `CHK(int_w, 1'b0)
      rd(PA, 1'b1, 8'hE0, 8'hFF, 1'b0, v);
      `CHK(v, 8'h04)
      rd(PA, 1'b1, 8'h1A, 8'hFF, 1'b0, v);
      `CHK(v, 8'h00)
      rd(PA, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, 8'h04)
      // master acknowledge makes the device send the register again
      m_u.start();
      m_u.xfer({PA, 1'b1}, 1'b1, r, k);
      `CHK(k, 1'b0)
      m_u.xfer(8'hFF, 1'b0, v, k);
      `CHK(v, 8'h04)
      m_u.xfer(8'hFF, 1'b1, v, k);
      `CHK(v, 8'h04)
      m_u.stop();
      idle(10);
   endtask
   // alert response: lose to a lower address first, then win
   task automatic t_ara();
      rd(`ADDR_ARA, 1'b0, 8'h00, 8'h47, 1'b0, v);
      `CHK(v, 8'h47)
      `CHK(int_oe, 1'b1)
      rd(`ADDR_ARA, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, {`ADDR_FIXED_HI, straps, 1'b1})
      `CHK(int_oe, 1'b0)
      pulse(8'h08);
      `CHK(int_oe, 1'b0)
   endtask
   // clear-all, then release while flags stay set
   task automatic t_rel();
      wr(PA, 8'h1A, 8'h80, 1'b0);
      rd(PA, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, 8'h00)
      pulse(8'h01);
      `CHK(int_oe, 1'b1)
      wr(PA, 8'h1A, 8'h40, 1'b0);
      `CHK(int_oe, 1'b0)
      pulse(8'h02);
      `CHK(int_oe, 1'b0)
      wr(PA, 8'h00, 8'h55, 1'b0);
      `CHK(n_stb, 2)
   endtask
   // an event inside a transaction only shows after the stop
   task automatic t_busy();
      wr(PA, 8'h1A, 8'h80, 1'b0);
      m_u.start();
      m_u.xfer({PA, 1'b0}, 1'b1, r, k);
      pulse(8'h02);
      `CHK(busy, 1'b1)
      `CHK(int_oe, 1'b0)
      m_u.xfer(8'h00, 1'b1, r, k);
      m_u.stop();
      idle(10);
      `CHK(busy, 1'b0)
      `CHK(int_oe, 1'b1)
   endtask
   // a new strap value moves the primary address and the alert reply
   task automatic t_strap();
      @(posedge mclk) straps <= 4'hA;
      idle(4);
      wr(PA, 8'h05, 8'h11, 1'b1);
      `CHK(n_stb, 2)
      rd({`ADDR_FIXED_HI, 4'hA}, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, 8'h02)
      rd(`ADDR_ARA, 1'b0, 8'h00, 8'hFF, 1'b0, v);
      `CHK(v, {`ADDR_FIXED_HI, 4'hA, 1'b1})
      `CHK(int_oe, 1'b0)
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      idle(16);
      rst_n <= 1'b1;
      idle(4);
      t_write();
      t_refuse();
      t_read();
      t_ara();
      t_rel();
      t_busy();
      t_strap();
      complete_run();
   end
   // the whole sequence needs well under a quarter of this span
   initial begin
      #2_000_000;
      mismatches++;
      complete_run();
   end
endmodule
